/* File: design/hdlc_desc_pkg.sv */
// Shared descriptor layout and constants for the descriptor host controller
// What the document requires of host and device
// R01: Host marks a frame descriptor ready once built; device clears and sets flags.
// R02: Device never reads the complete or ready flags of any descriptor.
// R03: Device writes an 8-bit receive status; bits 7..2 defined, 1..0 reserved.
// R04: Host sets list end on last ready descriptor; checks ready before changing it.
// R05: Without header writing, all received bytes go to buffers; limit ignored.
// R06: With header writing, host sets two-bit header limit: 01,10,11,00 = 1,2,3,4.
// R07: Frame fitting the header space: fits flag set, count stored, no buffers.
// R08: Larger frame: fits flag cleared, remaining data written to buffers.
// R09: Frame descriptor: flags, control, next, first buffer, two header words.
// R10: Host places buffer descriptors on 8-byte boundaries.
// R11: Host attaches transmit buffers at setup; receive uses queues or free list.
// R12: Last-buffer flag marks final buffer; host sets it on last transmit one.
// R13: Host builds buffer descriptor ready=1, in-use=0; device toggles them.
// R14: Next buffer pointer 0xFFFF means no further buffer descriptor.
// R15: Transmit count gives bytes sent and stays unchanged on release.
// R16: Receive count gives space; device overwrites it with bytes received.
// R17: Host gives every receive data buffer at least two bytes of space.
// R18: Data buffers start on an even byte address; length may be odd.
// R19: Buffer address is low word then high 4 bits; mode 4 swaps the words.
// R20: With header writing, receive frame descriptors align to 16 bytes, else 8.
package hdlc_desc_pkg;

  localparam int          ADDR_W         = 20;
  // Byte offsets of the frame descriptor words
  localparam logic [3:0]  FD_FLAGS_OFF   = 4'h0;
  localparam logic [3:0]  FD_CTRL_OFF    = 4'h2;
  localparam logic [3:0]  FD_NEXT_OFF    = 4'h4;
  localparam logic [3:0]  FD_FIRST_OFF   = 4'h6;
  localparam logic [3:0]  FD_HDR0_OFF    = 4'h8;
  localparam logic [3:0]  FD_HDR1_OFF    = 4'hA;
  // Byte offsets of the buffer descriptor words
  localparam logic [3:0]  BD_CTRL_OFF    = 4'h0;
  localparam logic [3:0]  BD_NEXT_OFF    = 4'h2;
  localparam logic [3:0]  BD_ADDR_LO_OFF = 4'h4;
  localparam logic [3:0]  BD_ADDR_HI_OFF = 4'h6;
  // Flag word fields
  localparam int          COMPLETE_BIT   = 15;
  localparam int          READY_BIT      = 14;
  localparam int          FITS_BIT       = 10;
  localparam int          STORED_HEADER_COUNT_LSB       = 8;
  localparam int          GOOD_CRC_BIT   = 7;
  localparam int          BAD_CRC_BIT    = 6;
  localparam int          PARTIAL_BIT    = 5;
  localparam int          OVERRUN_BIT    = 4;
  localparam int          ABORT_BIT      = 3;
  localparam int          LONG_FRAME_BIT = 2;
  // Control word fields
  localparam int          LIST_END_BIT   = 15;
  localparam int          HDR_LIMIT_LSB  = 8;
  // Buffer descriptor word 0 fields
  localparam int          LAST_BUF_BIT   = 15;
  localparam int          IN_USE_BIT     = 13;
  localparam int          COUNT_W        = 13;
  localparam logic [12:0] MIN_RX_SPACE   = 13'h0002;
  localparam logic [15:0] NO_NEXT_BD     = 16'hFFFF;
  // Alignment, as low address bits that must be zero
  localparam int          BD_ALIGN       = 3;
  localparam int          FD_ALIGN_HDR   = 4;
  localparam int          FD_ALIGN_PLAIN = 3;
  localparam logic [15:0] WORD_RST       = 16'h0000;

  typedef enum logic [1:0] {
    OP_BUILD_FD = 2'b00,
    OP_BUILD_BD = 2'b01,
    OP_READ     = 2'b10,
    OP_SET_END  = 2'b11
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WRITE = 2'b01,
    ST_READ  = 2'b10,
    ST_PUSH  = 2'b11
  } state_t;

endpackage

/* File: design/hdlc_frame_descriptor_engine.sv */
// Host controller that builds and inspects descriptors in shared memory
`timescale 1ns/100ps
module hdlc_frame_descriptor_engine #(
  parameter int RSP_DEPTH = 2
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        cmdValid,
  output logic             cmdReady,
  input  wire logic [1:0]  cmdOp,
  input  wire logic [19:0] cmdAddr,
  input  wire logic [15:0] cmdNext,
  input  wire logic [15:0] cmdPtr,
  input  wire logic [3:0]  cmdBufHigh,
  input  wire logic [12:0] cmdCount,
  input  wire logic [1:0]  cmdHdrLimit,
  input  wire logic        cmdListEnd,
  input  wire logic        cmdLast,
  input  wire logic        cmdRx,
  input  wire logic        writeHeaderSelect,
  input  wire logic        strapMode4,
  output logic             rspValid,
  input  wire logic        rspReady,
  output logic      [15:0] rspData,
  output logic             rspErr,
  output logic      [19:0] memAddr,
  output logic      [15:0] memWrData,
  output logic             memWr,
  output logic             memRd,
  input  wire logic [15:0] memRdData,
  input  wire logic        memAck
);
  import_free_check: assert final (1'b1);

  hdlc_desc_pkg::state_t state_r, state_nxt;
  hdlc_desc_pkg::op_t    op_r, op_nxt;
  logic [19:0] base_r, base_nxt;
  logic [2:0]  idx_r, idx_nxt, last_r, last_nxt;
  logic [15:0] words_r [6];
  logic [15:0] words_nxt [6];
  logic [3:0]  offs_r [6];
  logic [3:0]  offs_nxt [6];
  logic [15:0] rdWord_r, rdWord_nxt;
  logic        err_r, err_nxt;
  logic [19:0] memAddr_r, memAddr_nxt;
  logic [15:0] memData_r, memData_nxt;
  logic        bufInReady;
  logic        pushValid;

  // Low address bits that must be zero for the given alignment
  function automatic logic aligned(input logic [19:0] a, input int n);
    logic [19:0] mask;
    mask = 20'((64'h1 << n) - 64'h1);
    return (a & mask) == 20'h00000;
  endfunction

  function automatic logic [15:0] ctrlWord(input logic end_flag,
                                           input logic [1:0] lim,
                                           input logic hdr_on);
    logic [15:0] w;
    w = hdlc_desc_pkg::WORD_RST;
    w[hdlc_desc_pkg::LIST_END_BIT] = end_flag;
    // Limit is only meaningful with header writing on
    if (hdr_on)
      w[hdlc_desc_pkg::HDR_LIMIT_LSB +: 2] = lim; // R06 R05
    return w;
  endfunction

  always_comb
  begin
    state_nxt  = state_r;
    op_nxt     = op_r;
    base_nxt   = base_r;
    idx_nxt    = idx_r;
    last_nxt   = last_r;
    words_nxt  = words_r;
    offs_nxt   = offs_r;
    rdWord_nxt = rdWord_r;
    err_nxt    = err_r;
    unique case (state_r)
      hdlc_desc_pkg::ST_IDLE:
        if (cmdValid)
        begin
          op_nxt     = hdlc_desc_pkg::op_t'(cmdOp);
          base_nxt   = cmdAddr;
          idx_nxt    = 3'h0;
          rdWord_nxt = hdlc_desc_pkg::WORD_RST;
          err_nxt    = 1'b0;
          unique case (hdlc_desc_pkg::op_t'(cmdOp))
            hdlc_desc_pkg::OP_BUILD_FD:
            begin
              err_nxt = !aligned(cmdAddr, writeHeaderSelect ?
                                 hdlc_desc_pkg::FD_ALIGN_HDR :
                                 hdlc_desc_pkg::FD_ALIGN_PLAIN); // R20
              offs_nxt[0]  = hdlc_desc_pkg::FD_CTRL_OFF; // R09
              words_nxt[0] = ctrlWord(cmdListEnd, cmdHdrLimit,
                                      writeHeaderSelect); // R04
              offs_nxt[1]  = hdlc_desc_pkg::FD_NEXT_OFF;
              words_nxt[1] = cmdNext;
              offs_nxt[2]  = hdlc_desc_pkg::FD_FIRST_OFF; // R11
              words_nxt[2] = cmdPtr;
              offs_nxt[3]  = hdlc_desc_pkg::FD_HDR0_OFF;
              words_nxt[3] = hdlc_desc_pkg::WORD_RST;
              offs_nxt[4]  = hdlc_desc_pkg::FD_HDR1_OFF;
              words_nxt[4] = hdlc_desc_pkg::WORD_RST;
              // Ready goes out last so the device never sees half a build
              last_nxt = writeHeaderSelect ? 3'h5 : 3'h3;
              offs_nxt[last_nxt]  = hdlc_desc_pkg::FD_FLAGS_OFF;
              words_nxt[last_nxt] = hdlc_desc_pkg::WORD_RST;
              words_nxt[last_nxt][hdlc_desc_pkg::READY_BIT] = 1'b1; // R01
            end
            hdlc_desc_pkg::OP_BUILD_BD:
            begin
              err_nxt = !aligned(cmdAddr, hdlc_desc_pkg::BD_ALIGN) // R10
                        || cmdPtr[0] // R18
                        || (cmdRx && cmdCount <
                            hdlc_desc_pkg::MIN_RX_SPACE); // R17
              offs_nxt[0]  = hdlc_desc_pkg::BD_NEXT_OFF; // R14
              words_nxt[0] = cmdNext;
              // Mode 4 swaps the address words for one 32-bit fetch
              offs_nxt[1]  = strapMode4 ? hdlc_desc_pkg::BD_ADDR_HI_OFF
                                        : hdlc_desc_pkg::BD_ADDR_LO_OFF; // R19
              words_nxt[1] = cmdPtr;
              offs_nxt[2]  = strapMode4 ? hdlc_desc_pkg::BD_ADDR_LO_OFF
                                        : hdlc_desc_pkg::BD_ADDR_HI_OFF;
              words_nxt[2] = {12'h000, cmdBufHigh};
              offs_nxt[3]  = hdlc_desc_pkg::BD_CTRL_OFF;
              words_nxt[3] = {3'b000, cmdCount};
              words_nxt[3][hdlc_desc_pkg::LAST_BUF_BIT] =
                cmdLast && !cmdRx; // R12
              words_nxt[3][hdlc_desc_pkg::READY_BIT]  = 1'b1; // R13
              words_nxt[3][hdlc_desc_pkg::IN_USE_BIT] = 1'b0;
              last_nxt = 3'h3;
            end
            hdlc_desc_pkg::OP_READ:
            begin
              err_nxt     = cmdAddr[0];
              offs_nxt[0] = hdlc_desc_pkg::FD_FLAGS_OFF;
              last_nxt    = 3'h0;
            end
            hdlc_desc_pkg::OP_SET_END:
            begin
              err_nxt = !aligned(cmdAddr, hdlc_desc_pkg::FD_ALIGN_PLAIN);
              // Flags first; the control write needs ready still set
              offs_nxt[0]  = hdlc_desc_pkg::FD_FLAGS_OFF;
              offs_nxt[1]  = hdlc_desc_pkg::FD_CTRL_OFF;
              words_nxt[1] = ctrlWord(cmdListEnd, cmdHdrLimit,
                                      writeHeaderSelect);
              last_nxt = 3'h1;
            end
          endcase
          if (err_nxt)
            state_nxt = hdlc_desc_pkg::ST_PUSH;
          else if (cmdOp[1])
            state_nxt = hdlc_desc_pkg::ST_READ;
          else
            state_nxt = hdlc_desc_pkg::ST_WRITE;
        end
      hdlc_desc_pkg::ST_WRITE:
        if (memAck)
        begin
          if (idx_r == last_r)
            state_nxt = hdlc_desc_pkg::ST_PUSH;
          else
            idx_nxt = idx_r + 3'h1;
        end
      hdlc_desc_pkg::ST_READ:
        if (memAck)
        begin
          rdWord_nxt = memRdData;
          if (op_r == hdlc_desc_pkg::OP_SET_END)
          begin
            // Ready still set: go on to the control write; ready cleared means the device took it, so refuse
            if (memRdData[hdlc_desc_pkg::READY_BIT]) // R04
            begin
              idx_nxt   = 3'h1;
              state_nxt = hdlc_desc_pkg::ST_WRITE;
            end
            else
            begin
              err_nxt   = 1'b1;
              state_nxt = hdlc_desc_pkg::ST_PUSH;
            end
          end
          else
            state_nxt = hdlc_desc_pkg::ST_PUSH;
        end
      hdlc_desc_pkg::ST_PUSH:
        if (bufInReady)
          state_nxt = hdlc_desc_pkg::ST_IDLE;
    endcase
    memAddr_nxt = base_nxt + {16'h0000, offs_nxt[idx_nxt]};
    memData_nxt = words_nxt[idx_nxt];
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_r   <= hdlc_desc_pkg::ST_IDLE;
      op_r      <= hdlc_desc_pkg::OP_BUILD_FD;
      base_r    <= 20'h00000;
      idx_r     <= 3'h0;
      last_r    <= 3'h0;
      rdWord_r  <= hdlc_desc_pkg::WORD_RST;
      err_r     <= 1'b0;
      memAddr_r <= 20'h00000;
      memData_r <= hdlc_desc_pkg::WORD_RST;
      for (int i = 0; i < 6; i++)
      begin
        words_r[i] <= hdlc_desc_pkg::WORD_RST;
        offs_r[i]  <= 4'h0;
      end
    end
    else
    begin
      state_r   <= state_nxt;
      op_r      <= op_nxt;
      base_r    <= base_nxt;
      idx_r     <= idx_nxt;
      last_r    <= last_nxt;
      rdWord_r  <= rdWord_nxt;
      err_r     <= err_nxt;
      memAddr_r <= memAddr_nxt;
      memData_r <= memData_nxt;
      words_r   <= words_nxt;
      offs_r    <= offs_nxt;
    end
  end

  assign cmdReady  = (state_r == hdlc_desc_pkg::ST_IDLE);
  assign memWr     = (state_r == hdlc_desc_pkg::ST_WRITE);
  assign memRd     = (state_r == hdlc_desc_pkg::ST_READ);
  assign memAddr   = memAddr_r;
  assign memWrData = memData_r;
  assign pushValid = (state_r == hdlc_desc_pkg::ST_PUSH);

  // Answer path; a stalled user holds the engine in the push state once RSP_DEPTH answers fill the buffer
  rsp_buffer #(
    .WIDTH (17),
    .DEPTH (RSP_DEPTH)
  ) u_rsp (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .inValid  (pushValid),
    .inReady  (bufInReady),
    .inData   ({err_r, rdWord_r}),
    .outValid (rspValid),
    .outReady (rspReady),
    .outData  ({rspErr, rspData})
  );

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  logic fdFlagsWr;
  logic bdCtrlWr;
  assign fdFlagsWr = memWr && op_r == hdlc_desc_pkg::OP_BUILD_FD
                     && idx_r == last_r;
  assign bdCtrlWr  = memWr && op_r == hdlc_desc_pkg::OP_BUILD_BD
                     && idx_r == 3'h3;

  sequence fdBodyDone;
    memWr && memAck && op_r == hdlc_desc_pkg::OP_BUILD_FD
      && idx_r == last_r - 3'h1;
  endsequence

  sequence flagsReadyWrite;
    memWr && memAddr == base_r
      && memWrData[hdlc_desc_pkg::READY_BIT]
      && !memWrData[hdlc_desc_pkg::COMPLETE_BIT];
  endsequence

  AST_FD_READY_LAST: assert property ( // R01
    fdBodyDone |=> flagsReadyWrite)
    else $error("ready flag not written right after descriptor body");
  AST_FD_FIRST_CTRL: assert property ( // R09
    $rose(memWr) && op_r == hdlc_desc_pkg::OP_BUILD_FD
      |-> memAddr == base_r + 20'h00002)
    else $error("frame descriptor build did not start at control word");
  AST_BD_ALIGN: assert property ( // R10
    memWr && op_r == hdlc_desc_pkg::OP_BUILD_BD
      |-> base_r[2:0] == 3'h0)
    else $error("buffer descriptor written off an 8-byte boundary");
  AST_BD_FLAGS: assert property ( // R13
    bdCtrlWr |-> memAddr == base_r
      && memWrData[hdlc_desc_pkg::READY_BIT]
      && !memWrData[hdlc_desc_pkg::IN_USE_BIT])
    else $error("buffer descriptor not left ready and free");
  AST_RX_SPACE: assert property ( // R17
    cmdValid && cmdReady && cmdOp == 2'b01 && cmdRx
      && cmdCount < hdlc_desc_pkg::MIN_RX_SPACE
      |=> err_r && !memWr)
    else $error("receive buffer under two bytes");
  AST_BUF_EVEN: assert property ( // R18
    memWr && op_r == hdlc_desc_pkg::OP_BUILD_BD && idx_r == 3'h1
      |-> memWrData[0] == 1'b0)
    else $error("data buffer address is odd");
  AST_FD_ALIGN: assert property ( // R20
    fdFlagsWr |-> base_r[2:0] == 3'h0
      && (!writeHeaderSelect || base_r[3] == 1'b0 || last_r != 3'h5))
    else $error("frame descriptor misaligned");
  AST_END_NEEDS_READY: assert property ( // R04
    memWr && op_r == hdlc_desc_pkg::OP_SET_END
      |-> rdWord_r[hdlc_desc_pkg::READY_BIT])
    else $error("list end changed after device took descriptor");
  AST_HDR_LIMIT: assert property ( // R06
    memWr && op_r == hdlc_desc_pkg::OP_BUILD_FD && idx_r == 3'h0
      |-> memWrData[9:8] == (writeHeaderSelect ? $past(cmdHdrLimit, 1)
                                                : 2'b00)
      || $past(memWr, 1))
    else $error("header limit field wrong");
  AST_WR_HOLD: assert property ( // R09
    memWr && !memAck |=> memWr && $stable(memAddr) && $stable(memWrData))
    else $error("memory write dropped before acknowledge");
  AST_ERR_NO_MEM: assert property ( // R10
    cmdValid && cmdReady && cmdOp == 2'b01 && cmdAddr[2:0] != 3'h0
      |=> !memWr [*2])
    else $error("misaligned buffer descriptor reached memory");
endmodule

/* File: design/rsp_buffer.sv */
// Small FIFO holding answers until the user takes them
`timescale 1ns/100ps
module rsp_buffer #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 2
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int PTR_W = $clog2(DEPTH);

  // Pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_depthCheck
    $error("DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [PTR_W-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic [PTR_W:0]   level_r, level_nxt;
  logic             push, pop;

  assign inReady  = (level_r != (PTR_W + 1)'(DEPTH));
  assign outValid = (level_r != '0);
  assign outData  = mem_r[rdPtr_r];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb
  begin
    mem_nxt   = mem_r;
    wrPtr_nxt = wrPtr_r + PTR_W'(push);
    rdPtr_nxt = rdPtr_r + PTR_W'(pop);
    level_nxt = level_r + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);
    if (push)
      mem_nxt[wrPtr_r] = inData;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      level_r <= '0;
      for (int i = 0; i < DEPTH; i++)
        mem_r[i] <= '0;
    end
    else
    begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      level_r <= level_nxt;
      mem_r   <= mem_nxt;
    end
  end
endmodule

/* File: dv/desc_mem_model.sv */
// Shared memory model standing in for the descriptor device
`timescale 1ns/100ps
module desc_mem_model (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [19:0] memAddr,
  input  wire logic [15:0] memWrData,
  input  wire logic        memWr,
  input  wire logic        memRd,
  output logic      [15:0] memRdData,
  output logic             memAck
);
  logic [15:0] mem [int];
  int          waitCnt;
  int          nWrites;
  bit          slow;

  initial
  begin
    memAck    = 1'b0;
    memRdData = 16'h0000;
    waitCnt   = 0;
    nWrites   = 0;
    slow      = 1'b0;
  end

  // Read data is only valid with the ack; it toggles otherwise so that
  // a controller sampling it late sees garbage
  always @(posedge core_clk)
  begin
    memAck    <= 1'b0;
    memRdData <= ~memRdData;
    if (sys_rst)
      waitCnt <= 0;
    else if ((memWr || memRd) && !memAck)
    begin
      if (waitCnt > 0)
        waitCnt <= waitCnt - 1;
      else
      begin
        memAck  <= 1'b1;
        waitCnt <= slow ? $urandom_range(4, 1) : 0;
        if (memWr)
        begin
          mem[memAddr] = memWrData;
          nWrites++;
        end
        else
          memRdData <= mem.exists(memAddr) ? mem[memAddr] : 16'h0000;
      end
    end
  end

  // Device picks up a frame: complete and ready both drop
  task automatic take_fd(input int a);
    mem[a] = mem[a] & 16'h3FFF;
  endtask

  // Frame done: complete and ready set, status byte written
  // Fits flag set for a frame held in the header words, cleared otherwise
  task automatic finish_fd(input int a, input logic fits,
                           input logic [1:0] cnt, input logic [7:0] st);
    mem[a] = {2'b11, mem[a][13:11], fits, cnt, st[7:2], 2'b00};
  endtask
endmodule

/* File: dv/test_hdlc_frame_descriptor_engine.sv */
// Self-checking bench for the descriptor host controller
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
  begin \
    n_tests++; \
    if ((got) !== (ex)) \
    begin \
      n_mismatch++; \
      $display("wrong value %s exp %0h got %0h", nm, ex, got); \
    end \
  end
module test_hdlc_frame_descriptor_engine;
  logic core_clk, sys_rst, cmdValid, cmdReady, cmdListEnd, cmdLast, cmdRx;
  logic writeHeaderSelect, strapMode4, rspValid, rspReady, rspErr;
  logic memWr, memRd, memAck;
  logic [1:0]  cmdOp, cmdHdrLimit;
  logic [19:0] cmdAddr, memAddr;
  logic [15:0] cmdNext, cmdPtr, rspData, memWrData, memRdData;
  logic [3:0]  cmdBufHigh;
  logic [12:0] cmdCount;
  logic [15:0] refMem [int];
  int          qA [$];
  logic [15:0] qD [$];
  logic        rErr [$];
  logic [15:0] rData [$];
  int          expWrites, n_tests, n_mismatch;

  hdlc_frame_descriptor_engine uut (.*);
  desc_mem_model devMem (.*);

  always #10 core_clk = ~core_clk;

  //****************************************
  // Driving and checking
  //****************************************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic expw(input int a, input logic [15:0] d);
    refMem[a] = d;
    qA.push_back(a);
    qD.push_back(d);
    expWrites++;
  endtask

  task automatic issue(input logic [1:0] op, input logic [19:0] a);
    int          n;
    logic        bad;
    logic [15:0] ctl;
    logic [15:0] d;
    ctl = {cmdListEnd, 5'h00, writeHeaderSelect ? cmdHdrLimit : 2'h0, 8'h00};
    d   = 16'h0000;
    bad = 1'b0;
    case (op)
      2'b00:
      begin
        bad = writeHeaderSelect ? (a[3:0] != 4'h0)
                                : (a[2:0] != 3'h0);
        if (!bad)
        begin
          expw(a + 20'h2, ctl);
          expw(a + 20'h4, cmdNext);
          expw(a + 20'h6, cmdPtr);
          if (writeHeaderSelect)
          begin
            expw(a + 20'h8, 16'h0000);
            expw(a + 20'hA, 16'h0000);
          end
          expw(a, 16'h4000);
        end
      end
      2'b01:
      begin
        bad = (a[2:0] != 3'h0) || cmdPtr[0]
           || (cmdRx && cmdCount < 13'h0002);
        if (!bad)
        begin
          expw(a + 20'h2, cmdNext);
          expw(a + (strapMode4 ? 20'h6 : 20'h4), cmdPtr);
          expw(a + (strapMode4 ? 20'h4 : 20'h6), {12'h000, cmdBufHigh});
          expw(a, {cmdLast & !cmdRx, 2'b10, cmdCount});
        end
      end
      2'b10:
      begin
        bad = a[0];
        d   = refMem.exists(a) ? refMem[a] : 16'h0000;
      end
      default:
      begin
        d   = refMem.exists(a) ? refMem[a] : 16'h0000;
        bad = (a[2:0] != 3'h0) || !d[14];
        if (!bad)
          expw(a + 20'h2, ctl);
      end
    endcase
    rErr.push_back(bad);
    rData.push_back(bad ? 16'h0000 : d);
    @(negedge core_clk);
    cmdOp    = op;
    cmdAddr  = a;
    cmdValid = 1'b1;
    n = 0;
    while (cmdReady !== 1'b1 && n < 200)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n == 200)
    begin
      n_mismatch++;
      finish_test();
    end
    @(negedge core_clk);
    cmdValid = 1'b0;
  endtask

  task automatic collect();
    int          n;
    int          a;
    logic        e;
    logic [15:0] d;
    logic [15:0] w;
    n = 0;
    while (rspValid !== 1'b1 && n < 200)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n == 200)
    begin
      n_mismatch++;
      finish_test();
    end
    e = rErr.pop_front();
    d = rData.pop_front();
    `CHK("rspErr", e, rspErr)
    if (!e)
      `CHK("rspData", d, rspData)
    while (qA.size() > 0)
    begin
      a = qA.pop_front();
      w = qD.pop_front();
      `CHK("memory word", w, devMem.mem[a])
    end
    `CHK("write count", expWrites, devMem.nWrites)
    @(negedge core_clk);
  endtask

  task automatic run(input logic [1:0] op, input logic [19:0] a);
    issue(op, a);
    collect();
  endtask

  //****************************************
  // Scenarios
  //****************************************
  initial
  begin
    {core_clk, cmdValid, cmdOp, cmdAddr, cmdNext, cmdPtr} = '0;
    {cmdBufHigh, cmdCount, cmdHdrLimit, cmdListEnd, cmdLast, cmdRx} = '0;
    {writeHeaderSelect, strapMode4, expWrites, n_tests, n_mismatch} = '0;
    sys_rst  = 1'b1;
    rspReady = 1'b1;
    void'($urandom(32'hA0A1));
    repeat (4) @(negedge core_clk);
    sys_rst = 1'b0;
    `CHK("cmdReady", 1'b1, cmdReady)
    for (int i = 0; i < 8; i++)
    begin
      {writeHeaderSelect, cmdHdrLimit} = i[2:0];
      cmdListEnd  = i[0];
      cmdNext     = 16'($urandom);
      cmdPtr      = 16'($urandom);
      devMem.slow = i[0];
      run(2'b00, 20'h00100 + 20'(i) * 20'h00010);
    end
    for (int i = 0; i < 8; i++)
    begin
      {cmdRx, strapMode4, cmdLast} = i[2:0];
      cmdNext    = i[0] ? 16'hFFFF : 16'($urandom);
      cmdPtr     = 16'($urandom) & 16'hFFFE;
      cmdBufHigh = 4'($urandom);
      cmdCount   = 13'($urandom) | 13'h0002;
      run(2'b01, 20'h00200 + 20'(i) * 20'h00008);
    end
    // Refusals and their accepted neighbours
    writeHeaderSelect = 1'b1;
    run(2'b00, 20'h00308);
    writeHeaderSelect = 1'b0;
    run(2'b00, 20'h00308);
    run(2'b00, 20'h00314);
    run(2'b01, 20'h00404);
    cmdPtr = 16'h1235;
    run(2'b01, 20'h00408);
    {cmdPtr, cmdRx, cmdCount} = {16'h1234, 1'b1, 13'h0001};
    run(2'b01, 20'h00408);
    cmdCount = 13'h0002;
    run(2'b01, 20'h00408);
    run(2'b10, 20'h00409);
    // Answers wait in the buffer while the user stalls
    rspReady = 1'b0;
    issue(2'b10, 20'h00102);
    issue(2'b10, 20'h00408);
    repeat (5) @(negedge core_clk);
    `CHK("rspValid", 1'b1, rspValid)
    rspReady = 1'b1;
    collect();
    collect();
    // List end may only move while the ready flag is set: before the device takes the frame or after it finishes it
    cmdListEnd = 1'b1;
    run(2'b11, 20'h00308);
    devMem.take_fd(20'h00308);
    refMem[20'h00308] = refMem[20'h00308] & 16'h3FFF;
    run(2'b11, 20'h00308);
    devMem.finish_fd(20'h00308, 1'b1, 2'b10, 8'h84);
    refMem[20'h00308] = {2'b11, refMem[20'h00308][13:11], 3'b110, 8'h84};
    run(2'b10, 20'h00308);
    cmdListEnd = 1'b0;
    run(2'b11, 20'h00308);
    finish_test();
  end
endmodule
